//--- core/cba_top.sv
// Purpose: crc accelerator behind three special function registers
// Assumes: core gives one-cycle write strobes synchronous to clk_i
// Notes:   result pair readable every cycle, no wait states
`timescale 1ns/1ns
`default_nettype none
`include "cba_defines.svh"

module cba_top
    import cba_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      arst_n_i,
    input  wire logic      input_wr_i,
    input  wire logic      result_high_wr_i,
    input  wire logic      result_low_wr_i,
    input  wire cba_byte_t wdata_i,
    output var  cba_byte_t result_high_o,
    output var  cba_byte_t result_low_o,
    output var  cba_byte_t input_rdata_o
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic [1:0] rst_sync_next;
    logic       rst_n;

    always_comb begin
        rst_sync_next = {rst_sync_reg[0], `CBA_SYNC_SET};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_reg <= `CBA_SYNC_RST;
        end else begin
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ************************************************************
    // reference step, used only by the checks below
    // ************************************************************
    function automatic cba_crc_t ref_step_f(input cba_crc_t c,
                                            input cba_byte_t d);
        cba_crc_t r;
        logic     fb;
        r = c;
        for (int i = `CBA_BYTE_W - 1; i >= 0; i--) begin
            fb = r[`CBA_CRC_MSB] ^ d[i];
            r  = {r[`CBA_CRC_MSB-1:0], `CBA_ZERO_BIT};
            if (fb) begin
                r = r ^ `CBA_POLY;
            end
        end
        return r;
    endfunction : ref_step_f

    // ************************************************************
    // remainder datapath
    // ************************************************************
    cba_crc_t crc_reg;
    cba_crc_t crc_next;
    cba_crc_t stepped;

    // the byte sequence order is software's duty; hardware just
    // folds in whatever arrives, one byte per strobe
    cba_byte_step u_step (
        .crc_i  (crc_reg),
        .data_i (wdata_i),
        .crc_o  (stepped)
    );

    always_comb begin
        crc_next = crc_reg;
        if (input_wr_i) begin
            crc_next = stepped;
        end
        // a seed write wins over a same-cycle byte for its half,
        // while the byte step still updates the other half
        if (result_high_wr_i) begin
            crc_next[`CBA_HIGH_MSB:`CBA_HIGH_LSB] = wdata_i;
        end
        if (result_low_wr_i) begin
            crc_next[`CBA_LOW_MSB:`CBA_LOW_LSB] = wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= `CBA_RESULT_RST;
        end else begin
            crc_reg <= crc_next;
        end
    end

    // ************************************************************
    // register read side
    // ************************************************************
    // read straight from the remainder flops, so the value
    // is there on the cycle after the write, no extra stage
    assign result_high_o = crc_reg[`CBA_HIGH_MSB:`CBA_HIGH_LSB];
    assign result_low_o  = crc_reg[`CBA_LOW_MSB:`CBA_LOW_LSB];
    // write-only register: a read returns a fixed filler
    assign input_rdata_o = `CBA_INPUT_READ_VAL;

    // ************************************************************
    // checks
    // ************************************************************
    // bitwise model of one step; the checks compare against it
    // rather than against the unrolled network they guard
    cba_crc_t ref_stepped;
    assign ref_stepped = ref_step_f(crc_reg, wdata_i);

    logic any_wr;
    assign any_wr = input_wr_i | result_high_wr_i | result_low_wr_i;

    a_hold_idle: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !any_wr |=> $stable(crc_reg)
    ) else $error("remainder changed without a write");

    a_byte_step: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (input_wr_i && !result_high_wr_i && !result_low_wr_i)
        |=> crc_reg == ref_step_f($past(crc_reg), $past(wdata_i))
    ) else $error("byte step gave a wrong remainder");

    a_high_map: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (input_wr_i && !result_high_wr_i)
        |=> result_high_o == $past(ref_stepped[`CBA_HIGH_MSB:`CBA_HIGH_LSB])
    ) else $error("high result not remainder bits 15..8");

    a_low_map: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (input_wr_i && !result_low_wr_i)
        |=> result_low_o == $past(ref_stepped[`CBA_LOW_MSB:`CBA_LOW_LSB])
    ) else $error("low result not remainder bits 7..0");

    a_seed_high: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        result_high_wr_i |=> result_high_o == $past(wdata_i)
    ) else $error("high seed not stored");

    a_seed_low: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (result_low_wr_i && !input_wr_i && !result_high_wr_i)
        |=> result_low_o == $past(wdata_i) && $stable(result_high_o)
    ) else $error("low seed not stored or high disturbed");

    a_check_high: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (input_wr_i && !result_high_wr_i && !result_low_wr_i
         && wdata_i == result_high_o)
        |=> result_high_o == $past(result_low_o)
            && result_low_o == `CBA_ZERO_BYTE
    ) else $error("first check byte did not cancel high half");

    a_check_pair: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (input_wr_i && !result_high_wr_i && !result_low_wr_i
         && wdata_i == result_high_o)
        ##1 (input_wr_i && !result_high_wr_i && !result_low_wr_i
             && wdata_i == result_high_o)
        |=> crc_reg == `CBA_RESULT_RST
    ) else $error("check pair did not leave zero remainder");

    a_reset_clear: assert property (
        @(posedge clk_i)
        $rose(rst_n) |-> crc_reg == `CBA_RESULT_RST
                         && input_rdata_o == `CBA_INPUT_READ_VAL
    ) else $error("result pair not cleared by reset");

    // ************************************************************
    // collision, network, idle-hold and reset-window checks
    // ************************************************************
    // the unrolled network must agree with the plain bit loop
    a_step_net: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        input_wr_i |-> stepped == ref_stepped
    ) else $error("unrolled step differs from bitwise step");

    // a same-cycle seed owns its byte, the byte step keeps the other
    a_collide_high: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (input_wr_i && result_high_wr_i && !result_low_wr_i)
        |=> result_high_o == $past(wdata_i)
        && result_low_o == $past(ref_stepped[`CBA_LOW_MSB:`CBA_LOW_LSB])
    ) else $error("high seed lost against same-cycle byte");

    a_collide_low: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (input_wr_i && result_low_wr_i && !result_high_wr_i)
        |=> result_low_o == $past(wdata_i)
        && result_high_o == $past(ref_stepped[`CBA_HIGH_MSB:`CBA_HIGH_LSB])
    ) else $error("low seed lost against same-cycle byte");

    // outputs come straight from flops, so idle must mean still
    a_result_stand: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !any_wr |=> $stable(result_high_o) && $stable(result_low_o)
    ) else $error("result register changed without a write");

    // strobes while the reset or its two sync cycles last are dropped
    a_reset_hold: assert property (
        @(posedge clk_i)
        !rst_n |-> crc_reg == `CBA_RESULT_RST
    ) else $error("result pair moved while reset held");

endmodule : cba_top
`default_nettype wire

//--- core/cba_defines.svh
// Purpose: named constants of the byte-wide crc accelerator
// Assumes: included by bare name from every core file that needs it
// Notes:   polynomial bits 12, 5 and 0 set; bit 16 is implicit
`ifndef CBA_DEFINES_SVH
`define CBA_DEFINES_SVH

// ************************************************************
// widths and polynomial
// ************************************************************
`define CBA_CRC_W            16
`define CBA_BYTE_W           8
`define CBA_CRC_MSB          15
`define CBA_POLY             16'h1021

// ************************************************************
// field positions of the result pair
// ************************************************************
`define CBA_HIGH_MSB         15
`define CBA_HIGH_LSB         8
`define CBA_LOW_MSB          7
`define CBA_LOW_LSB          0

// ************************************************************
// reset and fixed values
// ************************************************************
`define CBA_RESULT_RST       16'h0000
`define CBA_SEED_RECOMMENDED 8'hFF
`define CBA_INPUT_READ_VAL   8'h00
`define CBA_ZERO_BYTE        8'h00
`define CBA_ZERO_BIT         1'b0
`define CBA_SYNC_RST         2'h0
`define CBA_SYNC_SET         1'b1

`endif

//--- core/cba_pkg.sv
// Purpose: shared types of the byte-wide crc accelerator
// Assumes: cba_defines.svh is on the include path
// Notes:   types only; numbers live in the defines header
`include "cba_defines.svh"

package cba_pkg;
    typedef logic [`CBA_CRC_W-1:0]  cba_crc_t;
    typedef logic [`CBA_BYTE_W-1:0] cba_byte_t;
endpackage : cba_pkg

//--- core/cba_byte_step.sv
// Purpose: advance a 16-bit crc remainder by one message byte
// Assumes: purely combinational, used once per written byte
// Notes:   galois form, bit 7 of the byte enters first
`timescale 1ns/1ns
`default_nettype none
`include "cba_defines.svh"

module cba_byte_step
    import cba_pkg::*;
(
    input  wire cba_crc_t  crc_i,
    input  wire cba_byte_t data_i,
    output var  cba_crc_t  crc_o
);

    // ************************************************************
    // eight unrolled shift stages
    // ************************************************************
    cba_crc_t stage [0:`CBA_BYTE_W];

    assign stage[0] = crc_i;

    genvar g;
    generate
        for (g = 0; g < `CBA_BYTE_W; g = g + 1) begin : g_bit
            logic fb;
            // msb of the byte meets the register msb first
            assign fb = stage[g][`CBA_CRC_MSB] ^ data_i[`CBA_BYTE_W-1-g];
            // feedback folded into the inner taps 12, 5 and 0
            assign stage[g+1] = {stage[g][`CBA_CRC_MSB-1:0], `CBA_ZERO_BIT}
                              ^ (fb ? `CBA_POLY : `CBA_RESULT_RST);
        end
    endgenerate

    assign crc_o = stage[`CBA_BYTE_W];

endmodule : cba_byte_step
`default_nettype wire

//--- dv/cba_core_model.sv
// Purpose: core-side model writing and reading the crc registers
// Assumes: tasks are entered just after a rising clk_i edge
// Notes:   strobes are held between calls so writes can go back to back
`timescale 1ns/1ns
`default_nettype none

module cba_core_model
    import cba_pkg::*;
(
    input  wire logic      clk_i,
    input  wire cba_byte_t result_high_i,
    input  wire cba_byte_t result_low_i,
    output var  logic      input_wr_o,
    output var  logic      result_high_wr_o,
    output var  logic      result_low_wr_o,
    output var  cba_byte_t wdata_o
);
    // ************************************************************
    // register access
    // ************************************************************
    initial begin
        {input_wr_o, result_high_wr_o, result_low_wr_o} = 3'h0;
        wdata_o = 8'h00;
    end

    // sel bits: input, high, low; one edge per call
    task automatic put(input logic [2:0] sel, input cba_byte_t d);
        {input_wr_o, result_high_wr_o, result_low_wr_o} = sel;
        wdata_o = d;
        @(posedge clk_i);
        #1;
    endtask : put

    // released data bus must not keep showing the last byte
    task automatic idle();
        {input_wr_o, result_high_wr_o, result_low_wr_o} = 3'h0;
        wdata_o = ~wdata_o;
        @(posedge clk_i);
        #1;
    endtask : idle

    task automatic seed(input cba_byte_t hi, input cba_byte_t lo);
        put(3'h2, hi);
        put(3'h1, lo);
    endtask : seed

    task automatic rd(output cba_crc_t r);
        r = {result_high_i, result_low_i};
    endtask : rd
endmodule : cba_core_model

`default_nettype wire

//--- dv/cba_top_tb.sv
// Purpose: self-checking bench of the crc accelerator
// Assumes: core model drives all register strobes
// Notes:   expected remainders come from a local bitwise model
`timescale 1ns/1ns
`default_nettype none
`include "cba_defines.svh"

module cba_top_tb
    import cba_pkg::*;
;
    logic      clk    = 1'b0;
    logic      arst_n = 1'b0;
    logic      in_wr, hi_wr, lo_wr;
    cba_byte_t wdata, res_hi, res_lo, in_rd;
    cba_crc_t  exp, got, st;
    int        n_fail = 0;
    int        num_checks = 0;
    string     msg = "123456789";

    always #5 clk = ~clk;

    cba_top uut (.clk_i(clk), .arst_n_i(arst_n), .input_wr_i(in_wr),
        .result_high_wr_i(hi_wr), .result_low_wr_i(lo_wr),
        .wdata_i(wdata), .result_high_o(res_hi), .result_low_o(res_lo),
        .input_rdata_o(in_rd));
    cba_core_model core (.clk_i(clk), .result_high_i(res_hi),
        .result_low_i(res_lo), .input_wr_o(in_wr),
        .result_high_wr_o(hi_wr), .result_low_wr_o(lo_wr),
        .wdata_o(wdata));

    // ************************************************************
    // reference and helpers
    // ************************************************************
    function automatic cba_crc_t step(cba_crc_t c, cba_byte_t d);
        c = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ `CBA_POLY) : (c << 1);
        end
        return c;
    endfunction : step

    task automatic chk(input cba_crc_t g, input cba_crc_t e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    // strobes inside reset and the sync cycles must be ignored
    // start one edge in, so no strobe races the model's own start
    task automatic do_reset();
        @(posedge clk);
        #1 arst_n = 1'b0;
        core.put(3'h3, 8'hA5);
        repeat (14) @(posedge clk);
        #1 arst_n = 1'b1;
        core.put(3'h7, 8'h5A);
        core.idle();
        core.rd(got);
        chk(got, 16'h0000);
        chk({8'h00, in_rd}, 16'h0000);
    endtask : do_reset

    // feed bytes, checking the remainder one cycle after each write
    task automatic feed(input string s, input cba_byte_t flip);
        for (int i = 0; i < s.len(); i++) begin
            core.put(3'h4, s[i] ^ (i == 4 ? flip : 8'h00));
            exp = step(exp, s[i] ^ (i == 4 ? flip : 8'h00));
            core.rd(got);
            chk(got, exp);
        end
    endtask : feed

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end

    initial begin
        do_reset();
        core.seed(8'hFF, 8'hFF);
        core.rd(got);
        chk(got, 16'hFFFF);
        exp = 16'hFFFF;
        feed(msg, 8'h00);
        chk(got, 16'h29B1);
        core.put(3'h4, 8'h29);
        core.put(3'h4, 8'hB1);
        core.rd(got);
        chk(got, 16'h0000);
        core.seed(8'hFF, 8'hFF);
        exp = 16'hFFFF;
        feed(msg, 8'h01);
        exp = step(step(exp, 8'h29), 8'hB1);
        core.put(3'h4, 8'h29);
        core.put(3'h4, 8'hB1);
        core.rd(got);
        chk(got, exp);
        core.put(3'h2, 8'h12);
        core.rd(got);
        chk(got, {8'h12, exp[7:0]});
        core.put(3'h1, 8'h34);
        core.rd(got);
        chk(got, 16'h1234);
        core.put(3'h6, 8'h3C);
        core.rd(got);
        st = step(16'h1234, 8'h3C);
        chk(got, {8'h3C, st[7:0]});
        exp = {8'h3C, st[7:0]};
        core.put(3'h5, 8'hC3);
        core.rd(got);
        st = step(exp, 8'hC3);
        chk(got, {st[15:8], 8'hC3});
        core.put(3'h7, 8'h81);
        core.idle();
        core.rd(got);
        chk(got, 16'h8181);
        do_reset();
        end_sim();
    end
endmodule : cba_top_tb

`default_nettype wire
